// File: pkg/ucg_map.svh
`ifndef UCG_MAP_SVH
`define UCG_MAP_SVH

// baud divisor
`define UCG_DIV_W 12
`define UCG_DIV_LO_W 8
`define UCG_DIV_HI_W 4
`define UCG_DIV_RST 12'h000
`define UCG_DIV_STEP 12'h001

// samples per bit
`define UCG_OVS_W 5
`define UCG_OVS_NORM 5'h10
`define UCG_OVS_DBL 5'h08
`define UCG_OVS_STEP 5'h01

// frame layout
`define UCG_DATA_W 9
`define UCG_FRAME_W 13
`define UCG_LEN_W 4
`define UCG_FRAME_OVH 4'h2
`define UCG_LEN_STEP 4'h1
`define UCG_FRAME_IDLE 13'h1FFF

// receive buffer depth
`define UCG_RX_DEPTH 2

`endif

// File: pkg/ucg_pkg.sv
`default_nettype none

`include "ucg_map.svh"

package ucg_pkg;

	typedef enum logic [3:0] {
		UCG_ASYNC_NORM = 4'h1,
		UCG_ASYNC_DBL = 4'h2,
		UCG_SYNC_MASTER = 4'h4,
		UCG_SYNC_SLAVE = 4'h8
	} ucg_clk_mode_t;

	typedef enum logic [1:0] {
		UCG_TX_IDLE = 2'h1,
		UCG_TX_SHIFT = 2'h2
	} ucg_tx_state_t;

	typedef enum logic [4:0] {
		UCG_RX_IDLE = 5'h01,
		UCG_RX_START = 5'h02,
		UCG_RX_DATA = 5'h04,
		UCG_RX_PAR = 5'h08,
		UCG_RX_STOP = 5'h10
	} ucg_rx_state_t;

	typedef struct packed {
		logic [`UCG_LEN_W-1:0] char_size;
		logic parity_en;
		logic parity_odd;
		logic two_stop;
	} ucg_frame_cfg_t;

	typedef struct packed {
		logic [`UCG_DATA_W-1:0] data;
		logic frame_err;
		logic parity_err;
		logic overrun;
	} ucg_rx_word_t;

endpackage

`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ucg_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic serial_power_gate = 1'b0, tx_enable = 1'b1, rx_enable = 1'b1;
	logic sync_mode_select = 1'b0, double_speed_select = 1'b0;
	logic xfer_clock_direction = 1'b0, sync_clock_polarity = 1'b0;
	ucg_frame_cfg_t frame_cfg = '{4'h8, 1'b1, 1'b0, 1'b0};
	logic [7:0] baud_divisor_low = 8'h01;
	logic [3:0] baud_divisor_high = 4'h0;
	logic baud_divisor_low_wr = 1'b1, tx_valid = 1'b0, rx_ready = 1'b0;
	logic [8:0] tx_data = 9'h000;
	logic tx_ready, rx_valid, tx_complete, tx_buf_empty, rx_complete;
	ucg_rx_word_t rx_word;
	ucg_clk_mode_t clk_mode;
	logic serial_in_pin, serial_out_pin, xfer_clock_pin_i = 1'b0;
	logic xfer_clock_pin_o, xfer_clock_pin_oe;
	int errors = 0, comparisons = 0;

	ucg_usart uut (.*);
	ucg_remote_station rs (.clk(clk), .line_in(serial_out_pin),
		.line_out(serial_in_pin));

	always #10 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [12:0] got, exp, input string msg);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_hi(ref logic s, input int lim, input string msg);
		int n;
		n = 0;
		while (s !== 1'b1)
		begin
			tick(1);
			n++;
			if (n > lim)
			begin
				check(1'b0, 1'b1, msg);
				conclude();
			end
		end
	endtask

	task automatic put(input logic [8:0] d);
		wait_hi(tx_ready, 2000, "tx ready");
		tx_valid = 1'b1;
		tx_data = d;
		tick(1);
		tx_valid = 1'b0;
	endtask

	task automatic pop();
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
	endtask

	task automatic mode(input logic s, dbl, dir, pol);
		sync_mode_select = s;
		double_speed_select = dbl;
		xfer_clock_direction = dir;
		sync_clock_polarity = pol;
		tick(2);
	endtask

	function automatic logic [12:0] mkf(input logic [8:0] d, input int n,
		input logic par, odd);
		logic [12:0] f;
		f = 13'h1FFF;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++)
			f[i + 1] = d[i];
		if (par)
			f[n + 1] = ^(d & ~(9'h1FF << n)) ^ odd;
		return f;
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [12:0] f;
		logic [12:0] e;
		bit ok;
		int per, edges;
		tick(4);
		rst = 1'b0;
		baud_divisor_low_wr = 1'b0;
		tick(1);
		check(serial_out_pin, 1'b1, "idle line");
		check(tx_buf_empty, 1'b1, "buffer empty");
		check(xfer_clock_pin_oe, 1'b0, "pin unused");
		// async sizes, both speeds, parity both kinds
		for (int nb = 5; nb <= 9; nb++)
		begin
			frame_cfg = '{nb[3:0], 1'b1, nb[1], 1'b0};
			mode(1'b0, nb[0], 1'b0, 1'b0);
			e = nb[0] ? UCG_ASYNC_DBL : UCG_ASYNC_NORM;
			check(clk_mode, e, "mode");
			per = nb[0] ? 16 : 32;
			put(9'h1A5);
			put(9'h05A);
			for (int k = 0; k < 2; k++)
			begin
				rs.get(f, nb + 3, per, k ? per : 900, ok);
				check(ok, 1'b1, "frame gap");
				e = mkf(k ? 9'h05A : 9'h1A5, nb, 1'b1, nb[1]);
				check(f, e, "tx frame");
			end
			wait_hi(tx_complete, per, "tx done");
			for (int c = 0; c < 3; c++)
			begin
				e = mkf(9'h0C3, nb, 1'b1, nb[1]);
				if (c > 0)
					e[nb + c] = ~e[nb + c];
				rs.send(e, nb + 3, per);
				wait_hi(rx_valid, per, "rx valid");
				e = {9'h0C3 & ~(9'h1FF << nb), c == 2, c == 1, 1'b0};
				check(rx_word, e, "rx word");
				pop();
			end
		end
		// third frame dropped, next word flags it
		for (int k = 0; k < 6; k++)
		begin
			if (k != 3 && k != 4)
				rs.send(mkf(9'h100, 9, 1'b1, 1'b0), 12, 16);
			if (k > 2)
			begin
				wait_hi(rx_valid, 16, "rx valid");
				check(rx_word.overrun, k == 5, "overrun");
				pop();
			end
		end
		// sync master, both polarities
		frame_cfg = '{4'h8, 1'b0, 1'b0, 1'b0};
		for (int p = 0; p < 2; p++)
		begin
			mode(1'b1, 1'b0, 1'b1, p[0]);
			check(clk_mode, UCG_SYNC_MASTER, "mode");
			check(xfer_clock_pin_oe, 1'b1, "clock out");
			check(xfer_clock_pin_o, p[0], "clock idle");
			put(9'h096);
			edges = 0;
			f = 13'h1FFF;
			for (int t = 0; t < 200 && tx_complete !== 1'b1; t++)
			begin
				e[0] = xfer_clock_pin_o;
				tick(1);
				if (e[0] === p[0] && xfer_clock_pin_o === !p[0])
					edges++;
				else if (e[0] === !p[0] && xfer_clock_pin_o === p[0])
					f[edges - 1] = serial_out_pin;
			end
			check(edges, 10, "change edges");
			check(f, mkf(9'h096, 8, 1'b0, 1'b0), "sync frame");
			check(xfer_clock_pin_o, p[0], "clock idle");
		end
		// sync slave, clock only from the pin
		mode(1'b1, 1'b0, 1'b0, 1'b0);
		check(clk_mode, UCG_SYNC_SLAVE, "mode");
		check(xfer_clock_pin_oe, 1'b0, "clock in");
		put(9'h0F0);
		tick(64);
		check(serial_out_pin, 1'b1, "no clock");
		check(rx_valid, 1'b0, "no clock rx");
		f = 13'h1FFF;
		e = mkf(9'h03C, 8, 1'b0, 1'b0);
		for (int t = 0; t < 400 && tx_complete !== 1'b1; t++)
		begin
			if (t % 8 == 0 && t < 104)
				rs.drive(e[t / 8]);
			if (t % 8 == 4 && t < 104)
				f[t / 8] = serial_out_pin;
			if (t % 4 == 0)
				xfer_clock_pin_i = ~xfer_clock_pin_i;
			tick(1);
		end
		check(tx_complete, 1'b1, "slave done");
		check(f, mkf(9'h0F0, 8, 1'b0, 1'b0), "slave frame");
		check(rx_valid, 1'b1, "slave rx valid");
		check(rx_word, {9'h03C, 3'b000}, "slave rx word");
		pop();
		// disable and gate
		tx_enable = 1'b0;
		rx_enable = 1'b0;
		tick(3);
		check(serial_out_pin, 1'b1, "disabled idle");
		serial_power_gate = 1'b1;
		tick(3);
		check(tx_ready, 1'b0, "gated ready");
		check(tx_buf_empty, 1'b0, "gated empty");
		conclude();
	end
endmodule // tb_top

`default_nettype wire

// File: testbench/ucg_remote_station.sv
`default_nettype none

module ucg_remote_station (
	// clock
	input wire logic clk,
	// serial lines
	input wire logic line_in,
	output var logic line_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial line_out = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// send frame bits lsb first, idle high after
	task automatic send(input logic [12:0] f, input int n, input int per);
		for (int i = 0; i < n; i++)
		begin
			line_out = f[i];
			repeat (per) @(posedge clk);
			#1;
		end
		line_out = 1'b1;
	endtask

	// capture frame at mid-bit, unused bits read high
	task automatic get(output logic [12:0] f, input int n, input int per,
		input int lim, output bit ok);
		int w;
		w = 0;
		f = 13'h1FFF;
		while (line_in !== 1'b0 && w < lim)
		begin
			@(posedge clk);
			#1;
			w++;
		end
		ok = (w < lim);
		repeat (per / 2) @(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			f[i] = line_in;
			if (i < n - 1)
				repeat (per) @(posedge clk);
		end
	endtask

	// drive one line level, used by synchronous transfers
	task automatic drive(input logic b);
		line_out = b;
	endtask
endmodule // ucg_remote_station

`default_nettype wire

// File: testbench/ucg_usart_checker.sv
`default_nettype none

module ucg_usart_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// controls
	input wire logic serial_power_gate,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic sync_mode_select,
	input wire logic double_speed_select,
	input wire logic xfer_clock_direction,
	// data handshakes
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire ucg_pkg::ucg_rx_word_t rx_word,
	// status
	input wire logic tx_complete,
	input wire logic tx_buf_empty,
	input wire logic rx_complete,
	input wire ucg_pkg::ucg_clk_mode_t clk_mode,
	// pins
	input wire logic serial_out_pin,
	input wire logic xfer_clock_pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import ucg_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	chk_oe_master: assert property (
		xfer_clock_pin_oe |-> sync_mode_select && xfer_clock_direction)
		else $error("clock pin driven outside master mode");
	chk_mode_async: assert property (
		!serial_power_gate && !sync_mode_select |=> clk_mode ==
		($past(double_speed_select) ? UCG_ASYNC_DBL : UCG_ASYNC_NORM))
		else $error("async clock mode wrong");
	chk_mode_sync: assert property (
		!serial_power_gate && sync_mode_select |=> clk_mode ==
		($past(xfer_clock_direction) ? UCG_SYNC_MASTER : UCG_SYNC_SLAVE))
		else $error("sync clock mode wrong");
	chk_rx_level: assert property (
		rx_complete == rx_valid)
		else $error("receive complete differs from valid");
	chk_gate_off: assert property (
		serial_power_gate [*2] |-> !tx_ready && !rx_valid)
		else $error("gated block still active");
	chk_rx_hold: assert property (
		rx_valid && !rx_ready && rx_enable && !serial_power_gate |=>
		rx_valid && $stable(rx_word))
		else $error("receive word lost while stalled");
	chk_done_pulse: assert property (
		tx_complete |-> serial_out_pin && tx_buf_empty ##1 !tx_complete)
		else $error("transmit complete pulse wrong");
	chk_tx_idle: assert property (
		!tx_enable [*2] |-> serial_out_pin && !tx_complete)
		else $error("disabled transmitter not idle high");
	chk_ready_drop: assert property (
		tx_valid && tx_ready |=> !tx_ready)
		else $error("buffer accepted a second word");

	cov_tx_done: cover property (tx_complete);
	cov_rx_perr: cover property (rx_valid && rx_word.parity_err);
	cov_master: cover property (clk_mode == UCG_SYNC_MASTER && tx_complete);
endmodule // ucg_usart_checker

bind ucg_usart ucg_usart_checker u_chk (.*);

`default_nettype wire

// File: verilog/ucg_fifo.sv
`default_nettype none

module ucg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	////////////////////////////////////////////////////////////////////////
	// storage
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pointers and fill level
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= (wr_q == LAST) ? '0 : PW'(wr_q + 1'b1);
			end
			if (pop)
			begin
				rd_q <= (rd_q == LAST) ? '0 : PW'(rd_q + 1'b1);
			end
			if (push & ~pop)
			begin
				cnt_q <= CW'(cnt_q + 1'b1);
			end
			else if (pop & ~push)
			begin
				cnt_q <= CW'(cnt_q - 1'b1);
			end
		end
	end

endmodule // ucg_fifo

`default_nettype wire

// File: verilog/ucg_usart.sv
`default_nettype none

`include "ucg_map.svh"

module ucg_usart (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire logic serial_power_gate,
	input wire logic tx_enable,
	input wire logic rx_enable,
	input wire logic sync_mode_select,
	input wire logic double_speed_select,
	input wire logic xfer_clock_direction,
	input wire logic sync_clock_polarity,
	input wire ucg_pkg::ucg_frame_cfg_t frame_cfg,
	// baud divisor
	input wire logic [`UCG_DIV_LO_W-1:0] baud_divisor_low,
	input wire logic [`UCG_DIV_HI_W-1:0] baud_divisor_high,
	input wire logic baud_divisor_low_wr,
	// transmit data
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [`UCG_DATA_W-1:0] tx_data,
	// receive data
	output logic rx_valid,
	input wire logic rx_ready,
	output ucg_pkg::ucg_rx_word_t rx_word,
	// events and status
	output logic tx_complete,
	output logic tx_buf_empty,
	output logic rx_complete,
	output ucg_pkg::ucg_clk_mode_t clk_mode,
	// pins
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic xfer_clock_pin_i,
	output logic xfer_clock_pin_o,
	output logic xfer_clock_pin_oe
);

	import ucg_pkg::*;

	function automatic logic [`UCG_FRAME_W-1:0] build_frame(
		input logic [`UCG_DATA_W-1:0] d,
		input ucg_frame_cfg_t c
	);
		logic [`UCG_FRAME_W-1:0] f;
		logic p;
		f = `UCG_FRAME_IDLE;
		f[0] = 1'b0;
		p = c.parity_odd;
		for (int i = 0; i < `UCG_DATA_W; i++)
		begin
			if (i < int'(c.char_size))
			begin
				f[i+1] = d[i];
				p = p ^ d[i];
			end
		end
		if (c.parity_en)
		begin
			f[c.char_size + `UCG_LEN_STEP] = p;
		end
		return f;
	endfunction

	logic en;
	ucg_clk_mode_t mode_d;
	ucg_clk_mode_t mode_q;
	logic is_sync;
	logic is_master;
	logic is_slave;
	logic [`UCG_DIV_W-1:0] div_val;
	logic [`UCG_DIV_W-1:0] div_cnt_q;
	logic baud_tick;
	logic [`UCG_OVS_W-1:0] ovs_last;
	logic [`UCG_OVS_W-1:0] ovs_mid;
	logic [`UCG_OVS_W-1:0] tx_pre_q;
	logic xck_q;
	logic xck_run;
	logic xck_end;
	logic xs1_q;
	logic xs2_q;
	logic xs3_q;
	logic rise;
	logic fall;
	logic change_edge;
	logic sample_edge;
	logic tx_bit_en;
	logic [`UCG_DATA_W-1:0] hold_q;
	logic hold_valid_q;
	ucg_tx_state_t tx_state_q;
	logic [`UCG_FRAME_W-1:0] tx_sh_q;
	logic [`UCG_LEN_W-1:0] tx_left_q;
	logic tx_complete_q;
	logic rs1_q;
	logic rs2_q;
	ucg_rx_state_t rx_state_q;
	logic [`UCG_OVS_W-1:0] rx_cnt_q;
	logic [2:0] vote_q;
	logic rx_done;
	logic rx_val;
	logic [`UCG_DATA_W-1:0] rx_sh_q;
	logic [`UCG_LEN_W-1:0] rx_bits_q;
	logic rx_par_q;
	logic par_err_q;
	logic ovr_pend_q;
	logic push_valid;
	logic push_ready;
	ucg_rx_word_t push_word;

	assign en = ~serial_power_gate;

	////////////////////////////////////////////////////////////////////////
	// clock mode decode
	always_comb
	begin
		if (~sync_mode_select)
		begin
			mode_d = double_speed_select ? UCG_ASYNC_DBL : UCG_ASYNC_NORM;
		end
		else
		begin
			// double speed ignored here
			mode_d = xfer_clock_direction ? UCG_SYNC_MASTER
				: UCG_SYNC_SLAVE;
		end
	end

	assign is_sync = sync_mode_select;
	assign is_master = (mode_d == UCG_SYNC_MASTER);
	assign is_slave = (mode_d == UCG_SYNC_SLAVE);
	assign clk_mode = mode_q;

	always_ff @(posedge clk)
	begin
		mode_q <= rst ? UCG_ASYNC_NORM : mode_d;
	end

	////////////////////////////////////////////////////////////////////////
	// baud rate generator
	assign div_val = {baud_divisor_high, baud_divisor_low};
	assign baud_tick = en & (div_cnt_q == `UCG_DIV_RST);

	always_ff @(posedge clk)
	begin
		if (rst | ~en)
		begin
			div_cnt_q <= `UCG_DIV_RST;
		end
		else if (baud_divisor_low_wr | (div_cnt_q == `UCG_DIV_RST))
		begin
			div_cnt_q <= div_val;
		end
		else
		begin
			div_cnt_q <= div_cnt_q - `UCG_DIV_STEP;
		end
	end

	// samples per bit: 16 normal, 8 double speed
	assign ovs_last = (mode_d == UCG_ASYNC_DBL) ? `UCG_OVS_DBL - `UCG_OVS_STEP
		: `UCG_OVS_NORM - `UCG_OVS_STEP;
	assign ovs_mid = `UCG_OVS_W'(ovs_last >> 1);

	always_ff @(posedge clk)
	begin
		if (rst | ~en | is_sync | (tx_state_q == UCG_TX_IDLE & ~hold_valid_q))
		begin
			tx_pre_q <= '0;
		end
		else if (baud_tick)
		begin
			tx_pre_q <= (tx_pre_q == ovs_last) ? '0
				: tx_pre_q + `UCG_OVS_STEP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer clock: master output, slave synchroniser
	assign xck_run = tx_enable & ((tx_state_q == UCG_TX_SHIFT) | hold_valid_q);
	// frame-ending change edge keeps the pin at its idle level
	assign xck_end = (tx_state_q == UCG_TX_SHIFT) & ~hold_valid_q
		& (tx_left_q == `UCG_LEN_STEP) & (xck_q == sync_clock_polarity);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			xck_q <= 1'b0;
		end
		else if (~en | ~is_master | ~xck_run)
		begin
			xck_q <= sync_clock_polarity;
		end
		else if (baud_tick & ~xck_end)
		begin
			xck_q <= ~xck_q;
		end
	end

	assign xfer_clock_pin_o = xck_q;
	assign xfer_clock_pin_oe = en & is_master;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			xs1_q <= sync_clock_polarity;
			xs2_q <= sync_clock_polarity;
			xs3_q <= sync_clock_polarity;
		end
		else
		begin
			xs1_q <= xfer_clock_pin_i;
			xs2_q <= xs1_q;
			xs3_q <= xs2_q;
		end
	end

	// slave edges come from the detector only
	always_comb
	begin
		rise = 1'b0;
		fall = 1'b0;
		if (en & is_master & xck_run & baud_tick)
		begin
			rise = ~xck_q;
			fall = xck_q;
		end
		else if (en & is_slave)
		begin
			rise = xs2_q & ~xs3_q;
			fall = ~xs2_q & xs3_q;
		end
	end

	assign change_edge = sync_clock_polarity ? fall : rise;
	assign sample_edge = sync_clock_polarity ? rise : fall;

	assign tx_bit_en = is_sync ? change_edge
		: (baud_tick & (tx_pre_q == ovs_last));

	////////////////////////////////////////////////////////////////////////
	// transmit write buffer
	assign tx_ready = en & tx_enable & ~hold_valid_q;
	assign tx_buf_empty = en & ~hold_valid_q;
	assign tx_complete = tx_complete_q;
	assign serial_out_pin = tx_sh_q[0];

	always_ff @(posedge clk)
	begin
		if (rst | ~en | ~tx_enable)
		begin
			hold_valid_q <= 1'b0;
			hold_q <= '0;
		end
		else if (tx_valid & tx_ready)
		begin
			hold_valid_q <= 1'b1;
			hold_q <= tx_data;
		end
		else if (tx_bit_en & ((tx_state_q == UCG_TX_IDLE)
			| (tx_left_q == `UCG_LEN_STEP)))
		begin
			hold_valid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit shifter
	always_ff @(posedge clk)
	begin
		if (rst | ~en | ~tx_enable)
		begin
			tx_state_q <= UCG_TX_IDLE;
			tx_sh_q <= `UCG_FRAME_IDLE;
			tx_left_q <= '0;
			tx_complete_q <= 1'b0;
		end
		else
		begin
			tx_complete_q <= 1'b0;
			if (tx_bit_en)
			begin
				case (tx_state_q)
					UCG_TX_IDLE:
					begin
						if (hold_valid_q)
						begin
							tx_state_q <= UCG_TX_SHIFT;
							tx_sh_q <= build_frame(hold_q, frame_cfg);
							tx_left_q <= frame_cfg.char_size + `UCG_FRAME_OVH
								+ `UCG_LEN_W'(frame_cfg.parity_en)
								+ `UCG_LEN_W'(frame_cfg.two_stop);
						end
					end
					UCG_TX_SHIFT:
					begin
						if (tx_left_q != `UCG_LEN_STEP)
						begin
							tx_sh_q <= {1'b1, tx_sh_q[`UCG_FRAME_W-1:1]};
							tx_left_q <= tx_left_q - `UCG_LEN_STEP;
						end
						else if (hold_valid_q)
						begin
							tx_sh_q <= build_frame(hold_q, frame_cfg);
							tx_left_q <= frame_cfg.char_size + `UCG_FRAME_OVH
								+ `UCG_LEN_W'(frame_cfg.parity_en)
								+ `UCG_LEN_W'(frame_cfg.two_stop);
						end
						else
						begin
							tx_state_q <= UCG_TX_IDLE;
							tx_sh_q <= `UCG_FRAME_IDLE;
							tx_complete_q <= 1'b1;
						end
					end
					default:
					begin
						tx_state_q <= UCG_TX_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive input synchroniser and bit recovery
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rs1_q <= 1'b1;
			rs2_q <= 1'b1;
		end
		else
		begin
			rs1_q <= serial_in_pin;
			rs2_q <= rs1_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst | ~en | is_sync | (rx_state_q == UCG_RX_IDLE))
		begin
			rx_cnt_q <= `UCG_OVS_STEP;
			vote_q <= '0;
		end
		else if (baud_tick)
		begin
			rx_cnt_q <= (rx_cnt_q == ovs_last) ? '0
				: rx_cnt_q + `UCG_OVS_STEP;
			if ((rx_cnt_q == ovs_mid - `UCG_OVS_STEP) | (rx_cnt_q == ovs_mid)
				| (rx_cnt_q == ovs_mid + `UCG_OVS_STEP))
			begin
				vote_q <= {vote_q[1:0], rs2_q};
			end
		end
	end

	// async: majority of three mid samples; sync: one sample per edge
	assign rx_done = is_sync ? sample_edge
		: (baud_tick & (rx_cnt_q == ovs_last));
	assign rx_val = is_sync ? rs2_q : ((vote_q[0] & vote_q[1])
		| (vote_q[1] & vote_q[2]) | (vote_q[0] & vote_q[2]));

	////////////////////////////////////////////////////////////////////////
	// receive frame machine
	always_ff @(posedge clk)
	begin
		if (rst | ~en | ~rx_enable)
		begin
			rx_state_q <= UCG_RX_IDLE;
			rx_sh_q <= '0;
			rx_bits_q <= '0;
			rx_par_q <= 1'b0;
			par_err_q <= 1'b0;
		end
		else
		begin
			case (rx_state_q)
				UCG_RX_IDLE:
				begin
					rx_bits_q <= '0;
					rx_par_q <= frame_cfg.parity_odd;
					par_err_q <= 1'b0;
					if (is_sync & sample_edge & ~rs2_q)
					begin
						rx_state_q <= UCG_RX_DATA;
					end
					else if (~is_sync & baud_tick & ~rs2_q)
					begin
						rx_state_q <= UCG_RX_START;
					end
				end
				UCG_RX_START:
				begin
					if (rx_done)
					begin
						rx_state_q <= rx_val ? UCG_RX_IDLE : UCG_RX_DATA;
					end
				end
				UCG_RX_DATA:
				begin
					if (rx_done)
					begin
						rx_sh_q <= {rx_val, rx_sh_q[`UCG_DATA_W-1:1]};
						rx_par_q <= rx_par_q ^ rx_val;
						rx_bits_q <= rx_bits_q + `UCG_LEN_STEP;
						if (rx_bits_q + `UCG_LEN_STEP == frame_cfg.char_size)
						begin
							rx_state_q <= frame_cfg.parity_en ? UCG_RX_PAR
								: UCG_RX_STOP;
						end
					end
				end
				UCG_RX_PAR:
				begin
					if (rx_done)
					begin
						par_err_q <= rx_par_q ^ rx_val;
						rx_state_q <= UCG_RX_STOP;
					end
				end
				UCG_RX_STOP:
				begin
					if (rx_done)
					begin
						rx_state_q <= UCG_RX_IDLE;
					end
				end
				default:
				begin
					rx_state_q <= UCG_RX_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive word assembly and overrun
	assign push_valid = (rx_state_q == UCG_RX_STOP) & rx_done;
	assign push_word.data = rx_sh_q >> (`UCG_DATA_W - frame_cfg.char_size);
	assign push_word.frame_err = ~rx_val;
	assign push_word.parity_err = par_err_q;
	assign push_word.overrun = ovr_pend_q;

	always_ff @(posedge clk)
	begin
		if (rst | ~en | ~rx_enable)
		begin
			ovr_pend_q <= 1'b0;
		end
		else if (push_valid & ~push_ready)
		begin
			ovr_pend_q <= 1'b1;
		end
		else if (push_valid)
		begin
			ovr_pend_q <= 1'b0;
		end
	end

	ucg_fifo #(
		.WIDTH($bits(ucg_rx_word_t)),
		.DEPTH(`UCG_RX_DEPTH)
	) u_rx_buf (
		.clk(clk),
		.rst(rst | ~en | ~rx_enable),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_word)
	);

	assign rx_complete = rx_valid;

endmodule // ucg_usart

`default_nettype wire
